// >>> inc/efs_pkg.sv
// package for the earth fault supervision block
// assumes a single pclk domain at 125 MHz and an APB slave register port
package efs_pkg;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [11:0] EFS_ADDR_CTRL = 12'h000;
  localparam logic [11:0] EFS_ADDR_EXT_DLY = 12'h004;
  localparam logic [11:0] EFS_ADDR_WARN_LVL = 12'h008;
  localparam logic [11:0] EFS_ADDR_TRIP_LVL = 12'h00C;
  localparam logic [11:0] EFS_ADDR_WARN_DLY = 12'h010;
  localparam logic [11:0] EFS_ADDR_TRIP_DLY = 12'h014;
  localparam logic [11:0] EFS_ADDR_RATED = 12'h018;
  localparam logic [11:0] EFS_ADDR_STATUS = 12'h01C;
  localparam logic [11:0] EFS_ADDR_INT_MASK = 12'h020;
  localparam logic [11:0] EFS_ADDR_LEVEL = 12'h024;

  // ************************************************************
  // control fields
  // ************************************************************
  localparam int EFS_CTRL_EXT_EN = 0;
  localparam int EFS_CTRL_SEL_LO = 1;
  localparam int EFS_CTRL_SEL_HI = 2;
  localparam int EFS_CTRL_START_SUP = 3;
  localparam int EFS_CTRL_INT_EN = 4;
  localparam logic [4:0] EFS_CTRL_RST = 5'h00;

  // status / mask bit positions
  localparam int EFS_ST_EXT = 0;
  localparam int EFS_ST_WARN = 1;
  localparam int EFS_ST_TRIP = 2;
  localparam int EFS_ST_LOW = 3;
  localparam int EFS_ST_W = 4;

  // ************************************************************
  // widths and timing
  // ************************************************************
  localparam int EFS_CUR_W = 16;
  localparam int EFS_SUM_W = 18;
  localparam int EFS_DLY_W = 16;
  localparam int EFS_EXT_DLY_W = 8;
  localparam real EFS_CLK_MHZ = 125.0;
  localparam real EFS_STEP_MS = 100.0;
  localparam int EFS_STEP_CYC = int'(EFS_STEP_MS * EFS_CLK_MHZ * 1000.0);
  localparam int EFS_STEP_CNT_W = 24;
  localparam logic [EFS_EXT_DLY_W-1:0] EFS_EXT_DLY_RST = 8'h00;
  localparam logic [EFS_DLY_W-1:0] EFS_DLY_RST = 16'h0000;
  localparam logic [EFS_CUR_W-1:0] EFS_LVL_RST = 16'hFFFF;
  localparam logic [EFS_CUR_W-1:0] EFS_RATED_RST = 16'h0000;
  // 20 percent of rated current: rated / 5
  localparam int EFS_MIN_DIV = 5;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic [EFS_CUR_W-1:0] l1;
    logic [EFS_CUR_W-1:0] l2;
    logic [EFS_CUR_W-1:0] l3;
  } efs_phase_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } efs_apb_req_s;

endpackage : efs_pkg

// >>> rtl/efs_top.sv
// earth fault supervision: external monitor input plus current-sum check
// assumes phase samples are signed two's complement, synchronous to pclk
// Overview of operation
// - external monitor accepted on any one of three multifunction inputs
// - option ignores external earth fault during motor start-up
// - external fault held off by delay of 0 to 25.5 s in 0.1 s steps
// - earth current is the sum of the three phase currents
// - warning when sum exceeds warn level for warn delay after start-up
// - trip when sum stays above trip level for trip delay after start
// - internal check only acts when the current sum is above 20 percent of rated
`timescale 1ns/1ns
`default_nettype none
module efs_top
  import efs_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // plant
  input wire logic multifunction_input_0,
  input wire logic multifunction_input_1,
  input wire logic multifunction_input_2,
  input wire logic motor_starting,
  input wire efs_phase_s phase_i,
  // results
  output logic ext_fault,
  output logic gf_warn,
  output logic gf_trip,
  output logic irq
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [4:0] ctrl;
    logic [EFS_EXT_DLY_W-1:0] ext_dly;
    logic [EFS_CUR_W-1:0] warn_lvl;
    logic [EFS_CUR_W-1:0] trip_lvl;
    logic [EFS_DLY_W-1:0] warn_dly;
    logic [EFS_DLY_W-1:0] trip_dly;
    logic [EFS_CUR_W-1:0] rated;
    logic [EFS_ST_W-1:0] status;
    logic [EFS_ST_W-1:0] mask;
    logic [EFS_STEP_CNT_W-1:0] tick_cnt;
    logic [EFS_EXT_DLY_W-1:0] ext_cnt;
    logic [EFS_DLY_W-1:0] warn_cnt;
    logic [EFS_DLY_W-1:0] trip_cnt;
    logic [EFS_SUM_W-1:0] level;
    logic ext;
    logic warn;
    logic trip;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } efs_state_s;

  efs_state_s s_q;
  efs_state_s s_d;

  // ************************************************************
  // combinational datapath
  // ************************************************************
  logic signed [EFS_SUM_W-1:0] sum;
  logic [EFS_SUM_W-1:0] mag;
  logic tick;
  logic ext_raw;
  logic ext_cond;
  logic int_on;
  logic warn_cond;
  logic trip_cond;
  logic above_min;
  logic [EFS_ST_W-1:0] ev;
  logic [EFS_ST_W-1:0] w1c;
  logic wr;
  logic rd;
  logic hit;

  always_comb begin
    sum = EFS_SUM_W'($signed(phase_i.l1)) + EFS_SUM_W'($signed(phase_i.l2))
        + EFS_SUM_W'($signed(phase_i.l3));
    mag = sum[EFS_SUM_W-1] ? EFS_SUM_W'(-sum) : EFS_SUM_W'(sum);
    tick = (s_q.tick_cnt == EFS_STEP_CNT_W'(EFS_STEP_CYC - 1));
    unique case (s_q.ctrl[EFS_CTRL_SEL_HI:EFS_CTRL_SEL_LO])
      2'h0: ext_raw = multifunction_input_0;
      2'h1: ext_raw = multifunction_input_1;
      2'h2: ext_raw = multifunction_input_2;
      default: ext_raw = 1'b0;
    endcase
    // start-up suppression is optional for the external path
    ext_cond = s_q.ctrl[EFS_CTRL_EXT_EN] && ext_raw
      && !(s_q.ctrl[EFS_CTRL_START_SUP] && motor_starting);
    int_on = s_q.ctrl[EFS_CTRL_INT_EN] && !motor_starting;
    // below a fifth of rated the sum is not trusted
    above_min = mag > EFS_SUM_W'(s_q.rated / EFS_CUR_W'(EFS_MIN_DIV));
    warn_cond = int_on && above_min
      && (mag > EFS_SUM_W'(s_q.warn_lvl));
    trip_cond = int_on && above_min
      && (mag > EFS_SUM_W'(s_q.trip_lvl));
    wr = psel && penable && pwrite;
    rd = psel && !penable && !pwrite;
    // decoded at setup so the error answer stands with pready either way
    hit = paddr inside {EFS_ADDR_CTRL, EFS_ADDR_EXT_DLY, EFS_ADDR_WARN_LVL,
      EFS_ADDR_TRIP_LVL, EFS_ADDR_WARN_DLY, EFS_ADDR_TRIP_DLY,
      EFS_ADDR_RATED, EFS_ADDR_STATUS, EFS_ADDR_INT_MASK, EFS_ADDR_LEVEL};
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    s_d = s_q;
    s_d.pready = psel && !penable;
    s_d.pslverr = psel && !penable && !hit;
    s_d.level = mag;
    s_d.tick_cnt = tick ? '0 : s_q.tick_cnt + 1'b1;

    // external delay counts 0.1 s ticks; zero setting passes at once
    if (!ext_cond) begin
      s_d.ext_cnt = '0;
      s_d.ext = 1'b0;
    end else if (s_q.ext_cnt >= s_q.ext_dly) begin
      s_d.ext = 1'b1;
    end else if (tick) begin
      s_d.ext_cnt = s_q.ext_cnt + 1'b1;
    end

    // internal delays count in 0.1 s ticks as well
    if (!warn_cond) begin
      s_d.warn_cnt = '0;
      s_d.warn = 1'b0;
    end else if (s_q.warn_cnt >= s_q.warn_dly) begin
      s_d.warn = 1'b1;
    end else if (tick) begin
      s_d.warn_cnt = s_q.warn_cnt + 1'b1;
    end

    // trip latches until the internal check is disabled
    if (!s_q.ctrl[EFS_CTRL_INT_EN]) begin
      s_d.trip = 1'b0;
      s_d.trip_cnt = '0;
    end else if (!trip_cond) begin
      s_d.trip_cnt = '0;
    end else if (s_q.trip_cnt >= s_q.trip_dly) begin
      s_d.trip = 1'b1;
    end else if (tick) begin
      s_d.trip_cnt = s_q.trip_cnt + 1'b1;
    end

    // interrupt events on rising edges of the results
    ev = '0;
    ev[EFS_ST_EXT] = s_d.ext && !s_q.ext;
    ev[EFS_ST_WARN] = s_d.warn && !s_q.warn;
    ev[EFS_ST_TRIP] = s_d.trip && !s_q.trip;
    ev[EFS_ST_LOW] = s_d.warn && !s_q.warn && !above_min;
    w1c = '0;

    if (wr && s_q.pready) begin
      unique case (paddr)
        EFS_ADDR_CTRL: s_d.ctrl = pwdata[4:0];
        EFS_ADDR_EXT_DLY: s_d.ext_dly = pwdata[EFS_EXT_DLY_W-1:0];
        EFS_ADDR_WARN_LVL: s_d.warn_lvl = pwdata[EFS_CUR_W-1:0];
        EFS_ADDR_TRIP_LVL: s_d.trip_lvl = pwdata[EFS_CUR_W-1:0];
        EFS_ADDR_WARN_DLY: s_d.warn_dly = pwdata[EFS_DLY_W-1:0];
        EFS_ADDR_TRIP_DLY: s_d.trip_dly = pwdata[EFS_DLY_W-1:0];
        EFS_ADDR_RATED: s_d.rated = pwdata[EFS_CUR_W-1:0];
        EFS_ADDR_STATUS: w1c = pwdata[EFS_ST_W-1:0];
        EFS_ADDR_INT_MASK: s_d.mask = pwdata[EFS_ST_W-1:0];
        EFS_ADDR_LEVEL: ;
        default: ;
      endcase
    end
    // set wins over a same-cycle clear
    s_d.status = (s_q.status & ~w1c) | ev;
    s_d.irq = |(s_d.status & s_d.mask);

    // writes answer with zero data too
    if (psel && !penable) begin
      s_d.prdata = '0;
    end
    if (rd) begin
      unique case (paddr)
        EFS_ADDR_CTRL: s_d.prdata[4:0] = s_q.ctrl;
        EFS_ADDR_EXT_DLY: s_d.prdata[EFS_EXT_DLY_W-1:0] = s_q.ext_dly;
        EFS_ADDR_WARN_LVL: s_d.prdata[EFS_CUR_W-1:0] = s_q.warn_lvl;
        EFS_ADDR_TRIP_LVL: s_d.prdata[EFS_CUR_W-1:0] = s_q.trip_lvl;
        EFS_ADDR_WARN_DLY: s_d.prdata[EFS_DLY_W-1:0] = s_q.warn_dly;
        EFS_ADDR_TRIP_DLY: s_d.prdata[EFS_DLY_W-1:0] = s_q.trip_dly;
        EFS_ADDR_RATED: s_d.prdata[EFS_CUR_W-1:0] = s_q.rated;
        EFS_ADDR_STATUS: s_d.prdata[EFS_ST_W-1:0] = s_q.status;
        EFS_ADDR_INT_MASK: s_d.prdata[EFS_ST_W-1:0] = s_q.mask;
        EFS_ADDR_LEVEL: s_d.prdata[EFS_SUM_W-1:0] = s_q.level;
        default: ;
      endcase
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.ctrl <= EFS_CTRL_RST;
      s_q.ext_dly <= EFS_EXT_DLY_RST;
      s_q.warn_lvl <= EFS_LVL_RST;
      s_q.trip_lvl <= EFS_LVL_RST;
      s_q.warn_dly <= EFS_DLY_RST;
      s_q.trip_dly <= EFS_DLY_RST;
      s_q.rated <= EFS_RATED_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign ext_fault = s_q.ext;
  assign gf_warn = s_q.warn;
  assign gf_trip = s_q.trip;
  assign irq = s_q.irq;

endmodule : efs_top
`default_nettype wire

// >>> sim/efs_monitor.sv
// port assertions for efs_top
// assumes one pclk domain, bound to every efs_top
`timescale 1ns/1ns
`default_nettype none
module efs_monitor
  import efs_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // plant and results
  input wire logic multifunction_input_0,
  input wire logic multifunction_input_1,
  input wire logic multifunction_input_2,
  input wire logic motor_starting,
  input wire logic ext_fault,
  input wire logic gf_warn,
  input wire logic gf_trip
);
  wire logic any_in = multifunction_input_0 | multifunction_input_1 |
    multifunction_input_2;
  wire logic clr_w = pready & pwrite & (paddr == EFS_ADDR_CTRL) & ~pwdata[4];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no pready after setup");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("pready too long");
  property p_err; pslverr |-> pready && prdata == 32'h0000_0000; endproperty
  a_err: assert property (p_err) else $error("bad error answer");
  property p_ext; $rose(ext_fault) |-> $past(any_in); endproperty
  a_ext: assert property (p_ext) else $error("fault with no input");
  property p_drop; !any_in [*3] |=> !ext_fault; endproperty
  a_drop: assert property (p_drop) else $error("fault kept");
  property p_start; motor_starting [*3] |=> !gf_warn; endproperty
  a_start: assert property (p_start) else $error("warn in start");
  // the trip falls two cycles after the access, so skip the cycle after it too
  property p_latch;
    gf_trip && !clr_w && !$past(clr_w) |=> gf_trip;
  endproperty
  a_latch: assert property (p_latch) else $error("trip lost");
  property p_clr; clr_w |-> ##[1:3] !gf_trip; endproperty
  a_clr: assert property (p_clr) else $error("trip not cleared");
  c_err: cover property (pslverr);
  c_ext: cover property ($rose(ext_fault));
  c_trip: cover property ($rose(gf_trip));
endmodule : efs_monitor
bind efs_top efs_monitor efs_monitor_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .multifunction_input_0(multifunction_input_0),
  .multifunction_input_1(multifunction_input_1),
  .multifunction_input_2(multifunction_input_2),
  .motor_starting(motor_starting), .ext_fault(ext_fault),
  .gf_warn(gf_warn), .gf_trip(gf_trip));
`default_nettype wire

// >>> sim/efs_rcm_model.sv
// residual current monitor wired to one multifunction input
// assumes its output is a driven level, low when healthy
`timescale 1ns/1ns
`default_nettype none
module efs_rcm_model (
  // command
  input wire logic fault_on,
  input wire logic [1:0] wired_to,
  // outputs
  output logic out_0,
  output logic out_1,
  output logic out_2
);
  // push-pull output: unwired inputs read low, not floating
  assign out_0 = fault_on & (wired_to == 2'h0);
  assign out_1 = fault_on & (wired_to == 2'h1);
  assign out_2 = fault_on & (wired_to == 2'h2);
endmodule : efs_rcm_model
`default_nettype wire

// >>> sim/test_efs_top.sv
// testbench for efs_top with a residual current monitor model
// assumes delays are 0 apart from the ext_hold check, so outputs follow within a few cycles
`timescale 1ns/1ns
`default_nettype none
module test_efs_top
  import efs_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, last_err, ext_fault, gf_warn, gf_trip, irq;
  logic in_0, in_1, in_2;
  logic starting = 1'b0;
  logic fault_on = 1'b0;
  logic [1:0] wired_to = 2'h0;
  efs_phase_s phase = '0;
  int bad_count = 0;
  int checked = 0;
  always #4 pclk = ~pclk;
  efs_top efs_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .multifunction_input_0(in_0), .multifunction_input_1(in_1),
    .multifunction_input_2(in_2), .motor_starting(starting),
    .phase_i(phase), .ext_fault(ext_fault), .gf_warn(gf_warn),
    .gf_trip(gf_trip), .irq(irq));
  efs_rcm_model efs_rcm_model_i (.fault_on(fault_on), .wired_to(wired_to),
    .out_0(in_0), .out_1(in_1), .out_2(in_2));
  task automatic test_done();
    $display("checks %0d errors %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
      bad_count++;
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never gets its answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [11:0] a, input logic [31:0] e,
    input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, rd, e);
  endtask : rdc
  task automatic idle();
    repeat (4) @(posedge pclk);
  endtask : idle
  initial begin
    #80000;
    bad_count++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(EFS_ADDR_CTRL, 32'h0000_0000, "ctrl");
    rdc(EFS_ADDR_TRIP_LVL, 32'h0000_FFFF, "trip_lvl");
    rdc(EFS_ADDR_EXT_DLY, 32'h0000_0000, "ext_dly");
    rdc(12'h040, 32'h0000_0000, "unmapped");
    chk("slverr", last_err, 32'h1);
    apb(1'b1, 12'h040, 32'h0000_0001);
    chk("wr_slverr", last_err, 32'h1);
    apb(1'b1, EFS_ADDR_EXT_DLY, 32'h0000_0001);
    chk("wr_ok", last_err, 32'h0);
    rdc(EFS_ADDR_EXT_DLY, 32'h0000_0001, "ext_dly_set");
    apb(1'b1, EFS_ADDR_CTRL, 32'h0000_0001);
    wired_to <= 2'h0;
    fault_on <= 1'b1;
    idle();
    // one step is 0.1 s, far beyond this wait
    chk("ext_hold", ext_fault, 32'h0);
    fault_on <= 1'b0;
    apb(1'b1, EFS_ADDR_EXT_DLY, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, EFS_ADDR_CTRL, 32'(1 | (i << 1)));
      wired_to <= 2'(i);
      fault_on <= 1'b1;
      idle();
      chk("ext_sel", ext_fault, 32'h1);
      wired_to <= 2'((i + 1) % 3);
      idle();
      chk("ext_other", ext_fault, 32'h0);
      fault_on <= 1'b0;
    end
    apb(1'b1, EFS_ADDR_INT_MASK, 32'h0000_0001);
    idle();
    chk("irq_on", irq, 32'h1);
    apb(1'b1, EFS_ADDR_STATUS, 32'h0000_0001);
    idle();
    chk("irq_off", irq, 32'h0);
    apb(1'b1, EFS_ADDR_CTRL, 32'h0000_000B);
    starting <= 1'b1;
    wired_to <= 2'h1;
    fault_on <= 1'b1;
    idle();
    chk("ext_start", ext_fault, 32'h0);
    starting <= 1'b0;
    idle();
    chk("ext_run", ext_fault, 32'h1);
    fault_on <= 1'b0;
    apb(1'b1, EFS_ADDR_RATED, 32'h0000_0064);
    apb(1'b1, EFS_ADDR_WARN_LVL, 32'h0000_001E);
    apb(1'b1, EFS_ADDR_TRIP_LVL, 32'h0000_0032);
    apb(1'b1, EFS_ADDR_CTRL, 32'h0000_0010);
    phase <= '{16'h001E, 16'h0014, 16'hFFF6};
    idle();
    chk("warn", gf_warn, 32'h1);
    chk("no_trip", gf_trip, 32'h0);
    rdc(EFS_ADDR_LEVEL, 32'h0000_0028, "level");
    starting <= 1'b1;
    idle();
    chk("warn_start", gf_warn, 32'h0);
    starting <= 1'b0;
    phase <= '{16'h001E, 16'h0028, 16'hFFF6};
    idle();
    chk("trip", gf_trip, 32'h1);
    phase <= '0;
    idle();
    chk("trip_held", gf_trip, 32'h1);
    apb(1'b1, EFS_ADDR_CTRL, 32'h0000_0000);
    idle();
    chk("trip_clr", gf_trip, 32'h0);
    apb(1'b1, EFS_ADDR_WARN_LVL, 32'h0000_0005);
    phase <= '{16'h000F, 16'h0000, 16'h0000};
    idle();
    chk("warn_off", gf_warn, 32'h0);
    apb(1'b1, EFS_ADDR_CTRL, 32'h0000_0010);
    idle();
    chk("warn_small", gf_warn, 32'h0);
    phase <= '{16'h0019, 16'h0000, 16'h0000};
    idle();
    chk("warn_big", gf_warn, 32'h1);
    test_done();
  end
endmodule : test_efs_top
`default_nettype wire
